/* common/boot_loader_pkg.sv */
// constants, register map and boot tables of the start-up loader
package boot_loader_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] REG_PLL_CFG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SECURITY = 8'h08;
    localparam logic [7:0] REG_CRC = 8'h0c;
    // pll configuration fields
    localparam int PLL_F_LSB = 0;
    localparam int PLL_R_LSB = 12;
    localparam int PLL_OD_LSB = 20;
    localparam int PLL_F_W = 12;
    localparam int PLL_R_W = 6;
    localparam int PLL_OD_W = 3;
    // boot settings: fixed output and reference dividers, feedback multiplier per strap pattern
    localparam logic [2:0] BOOT_OD = 3'h1;
    localparam logic [5:0] BOOT_R = 6'h00;
    localparam logic [11:0] BOOT_F_X40 = 12'h09f;
    localparam logic [11:0] BOOT_F_X16 = 12'h03f;
    localparam logic [11:0] BOOT_F_X8 = 12'h01f;
    localparam logic [11:0] BOOT_F_X4 = 12'h00f;
    localparam logic [1:0] STRAP_X40 = 2'h0;
    localparam logic [1:0] STRAP_X16 = 2'h3;
    localparam logic [1:0] STRAP_X8 = 2'h2;
    // security register bits
    localparam int SEC_JTAG_OFF = 0;
    localparam int SEC_LINK_OFF = 1;
    localparam int SEC_OTP_BOOT = 5;
    localparam int SEC_LOCK_LSB = 8;
    localparam int SEC_MASTER_LOCK = 12;
    localparam int SEC_JTAG_OTP_OFF = 13;
    localparam int SEC_DEBUG_OFF = 14;
    localparam logic [31:0] SEC_RESET = 32'h0000_0000;
    // status register fields
    localparam int STAT_DONE = 0;
    localparam int STAT_CRC_ERR = 1;
    localparam int STAT_OTP_BOOT = 2;
    localparam int STAT_STRAP_LSB = 4;
    // boot image
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] CRC_PRESET = 32'hffff_ffff;
    localparam logic [31:0] CRC_SKIP = 32'h0d15_ab1e;
    localparam logic [1:0] LAST_BYTE = 2'h3;
    // internal reset delay before boot
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOOT_DELAY_NS = 15000;
    localparam int BOOT_DELAY_CYC = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [11:0] boot_mult(input logic [1:0] strap);
        case (strap)
            STRAP_X40: boot_mult = BOOT_F_X40;
            STRAP_X16: boot_mult = BOOT_F_X16;
            STRAP_X8: boot_mult = BOOT_F_X8;
            default: boot_mult = BOOT_F_X4;
        endcase
    endfunction : boot_mult
endpackage : boot_loader_pkg

/* logic/pll_boot_security_loader.sv */
// tile start-up: pll straps, boot image loader, security register
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module pll_boot_security_loader
    import boot_loader_pkg::*;
#(
    parameter int RAM_AW = 16,
    parameter int OTP_AW = 11,
    parameter int OTP_WORDS = 2048
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic reset_pin_n,
    input wire logic [1:0] mode_strap,
    output logic gpio_pulldown_en,
    input wire logic flash_valid,
    input wire logic [7:0] flash_data,
    output logic flash_ready,
    output logic otp_rd_en,
    output logic otp_rd_sec,
    output logic [OTP_AW-1:0] otp_rd_addr,
    input wire logic otp_rd_valid,
    input wire logic [31:0] otp_rd_data,
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [31:0] ram_wdata,
    output logic run_start,
    output logic [RAM_AW-1:0] run_addr,
    output logic [2:0] output_divider,
    output logic [11:0] pll_feedback_mult,
    output logic [5:0] pll_ref_divider,
    output logic jtag_disable,
    output logic link_access_block,
    output logic [3:0] otp_sector_prog_block,
    output logic otp_sec_prog_block,
    output logic jtag_otp_block,
    output logic debug_pin_disable,
    output logic boot_error
);
    // ==========================================
    // boot sequencer
    typedef enum logic [10:0] {
        ST_HOLD = 11'h001,
        ST_SEC_REQ = 11'h002,
        ST_SEC_WAIT = 11'h004,
        ST_DELAY = 11'h008,
        ST_OTP_REQ = 11'h010,
        ST_OTP_WAIT = 11'h020,
        ST_LEN = 11'h040,
        ST_PROG = 11'h080,
        ST_CHECK = 11'h100,
        ST_RUN = 11'h200,
        ST_ERROR = 11'h400
    } boot_state_t;

    localparam logic [15:0] DELAY_LAST = 16'(BOOT_DELAY_CYC - 1);
    localparam logic [RAM_AW-1:0] RAM_BASE = '0;
    localparam logic [OTP_AW-1:0] OTP_LAST = OTP_AW'(OTP_WORDS - 1);

    boot_state_t st_reg;
    boot_state_t st_next;
    logic [15:0] dly_cnt_reg;
    logic [31:0] sec_reg;
    logic [31:0] crc_reg;
    logic [31:0] check_reg;
    logic [31:0] word_sh_reg;
    logic [31:0] rem_reg;
    logic [1:0] b_cnt_reg;
    logic [RAM_AW-1:0] word_idx_reg;
    logic [OTP_AW-1:0] otp_idx_reg;
    logic crc_err_reg;
    logic fl_take;
    logic word_done;
    logic [31:0] assembled;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic pll_wr;
    logic addr_ok;
    logic [31:0] rd_mux;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    assign flash_ready = (st_reg == ST_LEN) || (st_reg == ST_PROG) || (st_reg == ST_CHECK);
    assign fl_take = flash_valid && flash_ready;
    assign word_done = fl_take && (b_cnt_reg == LAST_BYTE);
    // first byte lands in the low lane
    assign assembled = {flash_data, word_sh_reg[31:8]};
    assign gpio_pulldown_en = (st_reg == ST_HOLD);
    assign otp_rd_en = (st_reg == ST_SEC_REQ) || (st_reg == ST_OTP_REQ);
    assign otp_rd_sec = (st_reg == ST_SEC_REQ);
    assign otp_rd_addr = otp_idx_reg;
    assign run_addr = RAM_BASE;
    assign boot_error = crc_err_reg;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_HOLD: st_next = ST_SEC_REQ;
            ST_SEC_REQ: st_next = ST_SEC_WAIT;
            ST_SEC_WAIT: if (otp_rd_valid) begin
                st_next = ST_DELAY;
            end
            ST_DELAY: if (dly_cnt_reg == DELAY_LAST) begin
                st_next = sec_reg[SEC_OTP_BOOT] ? ST_OTP_REQ : ST_LEN;
            end
            ST_OTP_REQ: st_next = ST_OTP_WAIT;
            ST_OTP_WAIT: if (otp_rd_valid) begin
                st_next = (otp_idx_reg == OTP_LAST) ? ST_RUN : ST_OTP_REQ;
            end
            ST_LEN: if (word_done) begin
                st_next = (assembled == 32'h0) ? ST_CHECK : ST_PROG;
            end
            ST_PROG: if (word_done && rem_reg == 32'h1) begin
                st_next = ST_CHECK;
            end
            ST_CHECK: if (word_done) begin
                if (assembled == CRC_SKIP || assembled == ~crc_reg) begin
                    st_next = ST_RUN;
                end else begin
                    st_next = ST_ERROR;
                end
            end
            ST_RUN: st_next = ST_RUN;
            ST_ERROR: st_next = ST_ERROR;
            default: st_next = ST_HOLD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !reset_pin_n) begin
            st_reg <= ST_HOLD;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (st_reg != ST_DELAY) begin
            dly_cnt_reg <= 16'h0;
        end else begin
            dly_cnt_reg <= dly_cnt_reg + 16'h1;
        end
    end

    // ==========================================
    // security register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sec_reg <= SEC_RESET;
        end else if (st_reg == ST_SEC_WAIT && otp_rd_valid) begin
            sec_reg <= otp_rd_data;
        end
    end

    assign jtag_disable = sec_reg[SEC_JTAG_OFF];
    assign link_access_block = sec_reg[SEC_LINK_OFF];
    assign otp_sector_prog_block = sec_reg[SEC_LOCK_LSB +: 4] | {4{sec_reg[SEC_MASTER_LOCK]}};
    assign otp_sec_prog_block = sec_reg[SEC_MASTER_LOCK];
    assign jtag_otp_block = sec_reg[SEC_JTAG_OTP_OFF];
    assign debug_pin_disable = sec_reg[SEC_DEBUG_OFF];

    // ==========================================
    // image parser and ram writer
    always_ff @(posedge sys_clk) begin
        if (st_reg == ST_HOLD) begin
            b_cnt_reg <= 2'h0;
            word_sh_reg <= 32'h0;
        end else if (fl_take) begin
            b_cnt_reg <= b_cnt_reg + 2'h1;
            word_sh_reg <= assembled;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (st_reg == ST_HOLD) begin
            crc_reg <= CRC_PRESET;
        end else if (fl_take && st_reg != ST_CHECK) begin
            crc_reg <= crc_step(crc_reg, flash_data);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (st_reg == ST_HOLD) begin
            rem_reg <= 32'h0;
            check_reg <= 32'h0;
        end else if (word_done && st_reg == ST_LEN) begin
            rem_reg <= assembled;
        end else if (word_done && st_reg == ST_PROG) begin
            rem_reg <= rem_reg - 32'h1;
        end else if (word_done && st_reg == ST_CHECK) begin
            check_reg <= assembled;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (st_reg == ST_HOLD) begin
            word_idx_reg <= RAM_BASE;
            otp_idx_reg <= '0;
        end else if (word_done && st_reg == ST_PROG) begin
            word_idx_reg <= word_idx_reg + RAM_AW'(1);
        end else if (st_reg == ST_OTP_WAIT && otp_rd_valid) begin
            word_idx_reg <= word_idx_reg + RAM_AW'(1);
            otp_idx_reg <= otp_idx_reg + OTP_AW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ram_we <= 1'b0;
            ram_addr <= RAM_BASE;
            ram_wdata <= 32'h0;
        end else begin
            ram_we <= (word_done && st_reg == ST_PROG) || (st_reg == ST_OTP_WAIT && otp_rd_valid);
            ram_addr <= word_idx_reg;
            ram_wdata <= (st_reg == ST_PROG) ? assembled : otp_rd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !reset_pin_n) begin
            run_start <= 1'b0;
            crc_err_reg <= 1'b0;
        end else begin
            run_start <= (st_next == ST_RUN) && (st_reg != ST_RUN);
            if (st_next == ST_ERROR) begin
                crc_err_reg <= 1'b1;
            end
        end
    end

    // ==========================================
    // pll settings
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            output_divider <= BOOT_OD;
            pll_ref_divider <= BOOT_R;
            pll_feedback_mult <= BOOT_F_X40;
        end else if (st_reg == ST_HOLD) begin
            output_divider <= BOOT_OD;
            pll_ref_divider <= BOOT_R;
            pll_feedback_mult <= boot_mult(mode_strap);
        end else if (pll_wr) begin
            output_divider <= hwdata[PLL_OD_LSB +: PLL_OD_W];
            pll_ref_divider <= hwdata[PLL_R_LSB +: PLL_R_W];
            pll_feedback_mult <= hwdata[PLL_F_LSB +: PLL_F_W];
        end
    end

    // ==========================================
    // ahb-lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;
    assign pll_wr = wr_pend_reg && (wr_addr_reg == REG_PLL_CFG);

    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            REG_PLL_CFG: begin
                rd_mux[PLL_OD_LSB +: PLL_OD_W] = output_divider;
                rd_mux[PLL_R_LSB +: PLL_R_W] = pll_ref_divider;
                rd_mux[PLL_F_LSB +: PLL_F_W] = pll_feedback_mult;
            end
            REG_STATUS: begin
                rd_mux[STAT_DONE] = (st_reg == ST_RUN);
                rd_mux[STAT_CRC_ERR] = crc_err_reg;
                rd_mux[STAT_OTP_BOOT] = sec_reg[SEC_OTP_BOOT];
                rd_mux[STAT_STRAP_LSB +: 2] = mode_strap;
            end
            REG_SECURITY: rd_mux = sec_reg;
            REG_CRC: rd_mux = ~crc_reg;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ==========================================
    // checks
    sequence leave_delay_s;
        (st_reg == ST_DELAY) ##1 (st_reg != ST_DELAY && st_reg != ST_HOLD);
    endsequence
    sequence last_check_byte_s;
        (st_reg == ST_CHECK) && word_done;
    endsequence
    pulldown_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !reset_pin_n |=> gpio_pulldown_en && !run_start && !flash_ready)
        else $error("pull-downs not on while reset pin low");
    strap_ratio_a: assert property (@(posedge sys_clk) disable iff (reset)
        (st_reg == ST_HOLD) ##1 (st_reg == ST_SEC_REQ) |-> output_divider == BOOT_OD
        && pll_ref_divider == BOOT_R && pll_feedback_mult == boot_mult($past(mode_strap)))
        else $error("boot pll settings do not match strap");
    boot_delay_a: assert property (@(posedge sys_clk) disable iff (reset)
        leave_delay_s |-> $past(dly_cnt_reg) == DELAY_LAST)
        else $error("boot started before internal reset delay");
    boot_source_a: assert property (@(posedge sys_clk) disable iff (reset)
        leave_delay_s |-> (st_reg == ST_OTP_REQ) == sec_reg[SEC_OTP_BOOT])
        else $error("wrong boot source for security bit");
    skip_marker_a: assert property (@(posedge sys_clk) disable iff (reset || !reset_pin_n)
        last_check_byte_s and (assembled == CRC_SKIP) |=> st_reg == ST_RUN ##1 !run_start)
        else $error("skip marker did not start program");
    crc_fail_a: assert property (@(posedge sys_clk) disable iff (reset || !reset_pin_n)
        last_check_byte_s and (assembled != CRC_SKIP) and (assembled != ~crc_reg)
        |=> (st_reg == ST_ERROR && boot_error && !run_start)[*3])
        else $error("crc mismatch not reported");
    sec_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        (st_reg == ST_SEC_WAIT && otp_rd_valid) |=> jtag_disable == $past(otp_rd_data[0])
        && jtag_otp_block == $past(otp_rd_data[13]) && debug_pin_disable == $past(otp_rd_data[14]))
        else $error("security outputs not loaded from otp");
    run_base_a: assert property (@(posedge sys_clk) disable iff (reset)
        run_start |-> run_addr == RAM_BASE && $past(st_reg) != ST_ERROR && st_reg == ST_RUN)
        else $error("program start wrong");
    pll_write_a: assert property (@(posedge sys_clk) disable iff (reset)
        pll_wr && st_reg != ST_HOLD |=> pll_feedback_mult == $past(hwdata[11:0])
        && output_divider == $past(hwdata[22:20]))
        else $error("pll config write lost");
endmodule : pll_boot_security_loader

/* dv/boot_flash_model.sv */
// behavioural embedded flash and otp behind the start-up loader
`timescale 1ns/1ps
module boot_flash_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic flash_ready,
    output logic flash_valid,
    output logic [7:0] flash_data,
    input wire logic otp_rd_en,
    input wire logic otp_rd_sec,
    input wire logic [10:0] otp_rd_addr,
    output logic otp_rd_valid,
    output logic [31:0] otp_rd_data
);
    logic [7:0] img [0:63];
    int len = 0;
    int pos = 0;
    bit slow = 0;
    logic [31:0] sec_word = 32'h0;
    int otp_wait = 0;
    logic [31:0] otp_word = 32'h0;
    logic phase = 1'b0;
    logic [7:0] last = 8'h00;

    // ======
    // image stream, stalls every other cycle when slow
    assign flash_valid = (pos < len) && !(slow && phase);
    assign flash_data = flash_valid ? img[pos] : ~last;

    always @(posedge sys_clk) begin
        phase <= ~phase;
        if (reset || !reset_pin_n) begin
            pos <= 0;
        end else if (flash_valid && flash_ready) begin
            last <= img[pos];
            pos <= pos + 1;
        end
    end

    // ======
    // otp answers after two cycles, five when slow
    always @(posedge sys_clk) begin
        otp_rd_valid <= (otp_wait == 1);
        otp_rd_data <= (otp_wait == 1) ? otp_word : ~otp_word;
        if (otp_wait > 0) otp_wait <= otp_wait - 1;
        if (otp_rd_en === 1'b1) begin
            otp_wait <= slow ? 5 : 2;
            otp_word <= otp_rd_sec ? sec_word : 32'h0a0a_0000 + 32'(otp_rd_addr);
        end
    end
endmodule : boot_flash_model

/* dv/tb_pll_boot_security_loader.sv */
// self-checking bench of the start-up loader
`timescale 1ns/1ps
module tb_pll_boot_security_loader;
    import boot_loader_pkg::*;
    localparam int OTP_N = 4;
    logic sys_clk, reset, hsel, hwrite, hready, reset_pin_n, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, otp_rd_data, ram_wdata, rd, exp_crc;
    logic [1:0] htrans, mode_strap;
    logic flash_valid, flash_ready, otp_rd_en, otp_rd_sec, otp_rd_valid, ram_we, run_start;
    logic [7:0] flash_data;
    logic [10:0] otp_rd_addr;
    logic [15:0] ram_addr, run_addr, run_at;
    logic [2:0] output_divider;
    logic [11:0] pll_feedback_mult;
    logic [5:0] pll_ref_divider;
    logic jtag_disable, link_access_block, otp_sec_prog_block, jtag_otp_block;
    logic debug_pin_disable, boot_error, gpio_pulldown_en;
    logic [3:0] otp_sector_prog_block;
    logic [15:0] ram_at [0:15];
    logic [31:0] ram_dat [0:15];
    logic [11:0] mult_tab [0:3] = '{12'h09f, 12'h00f, 12'h01f, 12'h03f};
    int err_count = 0;
    int comparisons = 0;
    int ram_cnt = 0;
    int run_cnt = 0;
    int first = 0;

    assign hready = hreadyout;

    pll_boot_security_loader #(.OTP_WORDS(OTP_N)) dut (
        .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_pin_n(reset_pin_n),
        .mode_strap(mode_strap), .gpio_pulldown_en(gpio_pulldown_en),
        .flash_valid(flash_valid), .flash_data(flash_data), .flash_ready(flash_ready),
        .otp_rd_en(otp_rd_en), .otp_rd_sec(otp_rd_sec), .otp_rd_addr(otp_rd_addr),
        .otp_rd_valid(otp_rd_valid), .otp_rd_data(otp_rd_data), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .run_start(run_start),
        .run_addr(run_addr), .output_divider(output_divider),
        .pll_feedback_mult(pll_feedback_mult), .pll_ref_divider(pll_ref_divider),
        .jtag_disable(jtag_disable), .link_access_block(link_access_block),
        .otp_sector_prog_block(otp_sector_prog_block),
        .otp_sec_prog_block(otp_sec_prog_block), .jtag_otp_block(jtag_otp_block),
        .debug_pin_disable(debug_pin_disable), .boot_error(boot_error)
    );

    boot_flash_model flash (
        .sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n),
        .flash_ready(flash_ready), .flash_valid(flash_valid), .flash_data(flash_data),
        .otp_rd_en(otp_rd_en), .otp_rd_sec(otp_rd_sec), .otp_rd_addr(otp_rd_addr),
        .otp_rd_valid(otp_rd_valid), .otp_rd_data(otp_rd_data)
    );

    // ======
    // ram writes and program start
    always @(posedge sys_clk) begin
        if (ram_we === 1'b1 && ram_cnt < 16) begin
            ram_at[ram_cnt] = ram_addr;
            ram_dat[ram_cnt] = ram_wdata;
            ram_cnt++;
        end
        if (run_start === 1'b1) begin
            run_cnt++;
            run_at = run_addr;
        end
    end

    // ======
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        check(32'(hresp), 32'h0);
        if (n >= 50) begin err_count++; stop_test(); end
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h0, d};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
        return c;
    endfunction : crc_byte

    // mode 0 good check word, 1 skip marker, 2 corrupted
    task automatic load_image(input int n, input int mode);
        logic [31:0] c, w;
        int k;
        c = 32'hffff_ffff;
        k = 0;
        for (int i = 0; i <= n + 1; i++) begin
            if (i == n + 1) begin
                exp_crc = ~c;
                w = (mode == 1) ? 32'h0d15_ab1e : exp_crc ^ {31'h0, mode == 2};
            end else w = (i == 0) ? 32'(n) : 32'hc0de_0100 + 32'(i - 1);
            for (int b = 0; b < 4; b++) begin
                flash.img[k] = w[8*b +: 8];
                if (i <= n) c = crc_byte(c, w[8*b +: 8]);
                k++;
            end
        end
        flash.len = k;
    endtask : load_image

    task automatic boot(input logic [1:0] s, input logic [31:0] sec, input bit sl);
        int n;
        flash.sec_word = sec;
        flash.slow = sl;
        reset_pin_n <= 1'b0;
        mode_strap <= s;
        repeat (4) @(posedge sys_clk);
        ram_cnt = 0;
        run_cnt = 0;
        first = 0;
        check(32'(gpio_pulldown_en), 32'h1);
        reset_pin_n <= 1'b1;
        n = 0;
        while (run_cnt == 0 && boot_error !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (flash_ready === 1'b1 && first == 0) first = n;
            if (n > 20000) begin err_count++; stop_test(); end
        end
        repeat (2) @(posedge sys_clk);
    endtask : boot

    task automatic check_prog(input int n, input logic [31:0] base);
        check(32'(ram_cnt), 32'(n));
        for (int i = 0; i < n; i++) begin
            check(32'(ram_at[i]), 32'(i));
            check(ram_dat[i], base + 32'(i));
        end
        check(32'(run_cnt), 32'h1);
        check(32'(run_at), 32'h0);
        check(32'(boot_error), 32'h0);
    endtask : check_prog

    function automatic logic [31:0] sec_outs();
        return 32'({debug_pin_disable, jtag_otp_block, otp_sec_prog_block,
                    otp_sector_prog_block, link_access_block, jtag_disable});
    endfunction : sec_outs

    // ======
    // clock and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        reset_pin_n = 1'b0;
        mode_strap = 2'h0;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            mode_strap <= 2'(s);
            repeat (3) @(posedge sys_clk);
            check(32'(gpio_pulldown_en), 32'h1);
            check(32'({output_divider, pll_ref_divider, pll_feedback_mult}),
                  32'({3'h1, 6'h0, mult_tab[s]}));
        end
        load_image(3, 0);
        boot(2'h2, 32'h0000_6b03, 1'b0);
        check(32'(first >= BOOT_DELAY_CYC && first <= 15000), 32'h1);
        check_prog(3, 32'hc0de_0100);
        check(sec_outs(), 32'h1af);
        rd_chk(REG_SECURITY, 32'h0000_6b03);
        rd_chk(REG_STATUS, 32'h0000_0021);
        rd_chk(REG_CRC, exp_crc);
        ahb(1'b1, REG_SECURITY, 32'hffff_ffff);
        rd_chk(REG_SECURITY, 32'h0000_6b03);
        rd_chk(8'h10, 32'h0);
        ahb(1'b1, REG_PLL_CFG, 32'h0030_50a7);
        @(posedge sys_clk);
        check(32'({output_divider, pll_ref_divider, pll_feedback_mult}), 32'h000c_50a7);
        rd_chk(REG_PLL_CFG, 32'h0030_50a7);
        load_image(0, 1);
        boot(2'h3, 32'h0, 1'b1);
        check_prog(0, 32'h0);
        check(32'({output_divider, pll_ref_divider, pll_feedback_mult}), 32'h0004_003f);
        load_image(2, 2);
        boot(2'h1, 32'h0, 1'b0);
        check(32'(boot_error), 32'h1);
        check(32'(run_cnt), 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'h3, 32'h2);
        boot(2'h0, 32'h0000_1020, 1'b1);
        check_prog(OTP_N, 32'h0a0a_0000);
        check(sec_outs(), 32'h07c);
        rd_chk(REG_STATUS, 32'h0000_0005);
        stop_test();
    end
endmodule : tb_pll_boot_security_loader
